// File: logic/fpps_pkg.sv
// Purpose: shared constants and types for the flash page program sequencer
// Assumes: 20 MHz core clock, 32-bit Avalon-MM register port
// Notes:   register offsets are byte addresses
package fpps_pkg;
	localparam int unsigned CLK_PERIOD_NS = 50;
	// modelled array programming time
	localparam int unsigned PROG_TIME_NS  = 2000;
	localparam int unsigned PROG_CYCLES   = (PROG_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int unsigned CNT_W         = 16;

	localparam logic [3:0] OFS_FCTL = 4'h0;
	localparam logic [3:0] OFS_NVM  = 4'h4;
	localparam logic [3:0] OFS_STAT = 4'h8;

	// flash_control_reg field layout
	localparam int unsigned FC_KEY_HI = 7;
	localparam int unsigned FC_KEY_LO = 4;
	localparam int unsigned FC_MAP    = 3;
	localparam int unsigned FC_SP_HI  = 2;
	localparam int unsigned FC_SP_LO  = 1;
	localparam int unsigned FC_BUSY   = 0;
	// nvm_control_reg field layout
	localparam int unsigned NVM_AUTO_PAGE_ERASE  = 6;
	localparam int unsigned NVM_ERR   = 2;
	// status register layout
	localparam int unsigned ST_BUSY   = 0;
	localparam int unsigned ST_ARMED  = 1;
	localparam int unsigned ST_STALL  = 2;

	localparam logic [3:0] KEY_ARM = 4'h5;
	localparam logic [3:0] KEY_GO  = 4'ha;
	localparam logic [1:0] SP_CODE = 2'b00;
	localparam logic [1:0] SP_SIG  = 2'b01;
	localparam logic [1:0] SP_FUSE = 2'b10;
	localparam logic [1:0] SP_RSVD = 2'b11;

	localparam int unsigned BUF_DEPTH = 64;
	localparam logic [5:0]  LAST_IDX  = 6'h3f;
	localparam logic [6:0]  PAGE_BASE = 7'h00;
	localparam int unsigned A_PG_HI   = 15;
	localparam int unsigned A_PG_LO   = 7;
	localparam int unsigned A_HALF    = 6;
	localparam int unsigned A_IDX_HI  = 5;

	typedef enum logic [2:0] {
		FPPS_IDLE   = 3'b000,
		FPPS_ERASE  = 3'b001,
		FPPS_WRITE  = 3'b010,
		FPPS_SETTLE = 3'b011,
		FPPS_DONE   = 3'b100
	} fpps_state_e;

	typedef struct packed {
		logic [15:0] addr;
		logic [7:0]  data;
	} fpps_xwr_s;

	typedef struct packed {
		logic        erase;
		logic        wr;
		logic [1:0]  space;
		logic [15:0] addr;
		logic [7:0]  data;
	} fpps_flash_s;
endpackage : fpps_pkg

// File: logic/fpps_top.sv
// Purpose: flash page program sequencer with half-page buffer and launch key
// Assumes: core and bus share clock; brownout arrives asynchronously
// Notes:   flash array ANDs write data into cells, so only zeros program
//
// Contract
// - launch needs key 5 then key A
// - space 00 programs code space
// - space 01 programs user signature
// - space 10 programs user fuses
// - instruction between key writes aborts launch
// - busy high while programming runs
// - brown-out abort sets error flag
// - 64-byte buffer programs one half-page
// - any 1 to 64 loaded bytes accepted
// - loaded location ignores further loads
// - buffer emptied after each operation
// - no auto-erase: only loaded bytes written
// - auto-erase erases whole page first
// - unloaded bytes read FFh after erase
// - last load selects target page
// - internal launch stalls core; external polls
// - space 00 maps code for code reads
// - space 01 maps signature region
// - space 10 maps fuse region
// - control layout: key, map, space, busy
// - buffer map redirects data writes
//
// Added by the designer: the address map and the Avalon-MM register port.
`timescale 1ns/1ps
module fpps_top
	import fpps_pkg::*;
(
	input  wire logic        clock,
	input  wire logic        srst,
	input  wire logic [3:0]  avs_address,
	input  wire logic        avs_read,
	input  wire logic        avs_write,
	input  wire logic [31:0] avs_writedata,
	output logic      [31:0] avs_readdata,
	output logic             avs_waitrequest,
	input  wire logic        xwr_valid,
	input  wire fpps_xwr_s   xwr,
	input  wire logic        instr_step,
	input  wire logic        exec_internal,
	input  wire logic        brownout,
	output logic             ram_wr_valid,
	output fpps_xwr_s        ram_wr,
	output logic      [1:0]  code_space,
	output logic             cpu_stall,
	output fpps_flash_s      flash
);
	logic             wait_q;
	logic [31:0]      rdata_q;
	logic             map_q;
	logic [1:0]       space_q;
	logic             armed_q;
	logic             auto_page_erase_q;
	logic             err_q;
	logic             busy_q;
	logic             stall_q;
	logic             bo_m_q;
	logic             bo_s_q;
	fpps_state_e      st_q;
	logic [5:0]       idx_q;
	logic [CNT_W-1:0] cnt_q;
	logic [1:0]       sp_run_q;
	logic [8:0]       page_q;
	logic             half_q;
	logic [7:0]       buf_q [BUF_DEPTH];
	logic [63:0]      loaded_q;
	logic             ram_v_q;
	fpps_xwr_s        ram_q;
	fpps_flash_s      flash_q;

	logic       done;
	logic       fc_wr;
	logic       nvm_wr;
	logic [3:0] key;
	logic [1:0] wsp;
	logic       start;
	logic       abort;
	logic       ld;
	logic [5:0] ld_idx;
	logic       clr;

	assign done   = (avs_read || avs_write) && !wait_q;
	assign fc_wr  = done && avs_write && avs_address == OFS_FCTL;
	assign nvm_wr = done && avs_write && avs_address == OFS_NVM;
	assign key    = avs_writedata[FC_KEY_HI:FC_KEY_LO];
	assign wsp    = avs_writedata[FC_SP_HI:FC_SP_LO];
	// reserved space and unarmed key A start nothing
	assign start  = fc_wr && key == KEY_GO && armed_q && wsp != SP_RSVD
		&& st_q == FPPS_IDLE;
	assign abort  = bo_s_q && st_q != FPPS_IDLE;
	assign ld     = xwr_valid && map_q && st_q == FPPS_IDLE;
	assign ld_idx = xwr.addr[A_IDX_HI:0];
	assign clr    = st_q == FPPS_DONE || abort;

	// one wait cycle per access keeps read data a registered value
	always_ff @(posedge clock) begin
		if (srst) begin
			wait_q <= 1'b1;
		end else if (!wait_q) begin
			wait_q <= 1'b1;
		end else if (avs_read || avs_write) begin
			wait_q <= 1'b0;
		end
	end

	always_ff @(posedge clock) begin
		if (srst) begin
			rdata_q <= 32'h0;
		end else if (wait_q && avs_read) begin
			rdata_q <= 32'h0;
			case (avs_address)
				OFS_FCTL: begin
					rdata_q[FC_MAP]              <= map_q;
					rdata_q[FC_SP_HI:FC_SP_LO]   <= space_q;
					rdata_q[FC_BUSY]             <= busy_q;
				end
				OFS_NVM: begin
					rdata_q[NVM_AUTO_PAGE_ERASE] <= auto_page_erase_q;
					rdata_q[NVM_ERR]  <= err_q;
				end
				OFS_STAT: begin
					rdata_q[ST_BUSY]  <= busy_q;
					rdata_q[ST_ARMED] <= armed_q;
					rdata_q[ST_STALL] <= stall_q;
				end
				default: begin
					rdata_q <= 32'h0;
				end
			endcase
		end
	end

	// control fields; written value also selects code-read mapping
	always_ff @(posedge clock) begin
		if (srst) begin
			map_q   <= 1'b0;
			space_q <= SP_CODE;
		end else if (fc_wr) begin
			map_q   <= avs_writedata[FC_MAP];
			space_q <= wsp;
		end
	end

	always_ff @(posedge clock) begin
		if (srst) begin
			armed_q <= 1'b0;
		end else if (fc_wr) begin
			armed_q <= key == KEY_ARM && st_q == FPPS_IDLE;
		end else if (instr_step) begin
			armed_q <= 1'b0;
		end
	end

	always_ff @(posedge clock) begin
		if (srst) begin
			auto_page_erase_q <= 1'b0;
		end else if (nvm_wr) begin
			auto_page_erase_q <= avs_writedata[NVM_AUTO_PAGE_ERASE];
		end
	end

	// set wins over a same-cycle software clear
	always_ff @(posedge clock) begin
		if (srst) begin
			err_q <= 1'b0;
		end else if (abort) begin
			err_q <= 1'b1;
		end else if (nvm_wr) begin
			err_q <= err_q & avs_writedata[NVM_ERR];
		end
	end

	always_ff @(posedge clock) begin
		if (srst) begin
			bo_m_q <= 1'b0;
			bo_s_q <= 1'b0;
		end else begin
			bo_m_q <= brownout;
			bo_s_q <= bo_m_q;
		end
	end

	// array has no reset; loaded_q gates every flash write of its data
	always_ff @(posedge clock) begin
		if (ld && !loaded_q[ld_idx]) begin
			buf_q[ld_idx] <= xwr.data;
		end
	end

	always_ff @(posedge clock) begin
		if (srst) begin
			loaded_q <= 64'h0;
		end else if (clr) begin
			loaded_q <= 64'h0;
		end else if (ld) begin
			loaded_q[ld_idx] <= 1'b1;
		end
	end

	always_ff @(posedge clock) begin
		if (srst) begin
			page_q <= 9'h0;
			half_q <= 1'b0;
		end else if (ld) begin
			page_q <= xwr.addr[A_PG_HI:A_PG_LO];
			half_q <= xwr.addr[A_HALF];
		end
	end

	always_ff @(posedge clock) begin
		if (srst) begin
			ram_v_q <= 1'b0;
			ram_q   <= '0;
		end else begin
			ram_v_q <= xwr_valid && !map_q;
			ram_q   <= xwr;
		end
	end

	always_ff @(posedge clock) begin
		if (srst) begin
			st_q     <= FPPS_IDLE;
			idx_q    <= 6'h0;
			cnt_q    <= '0;
			sp_run_q <= SP_CODE;
		end else if (abort) begin
			st_q <= FPPS_IDLE;
		end else begin
			case (st_q)
				FPPS_IDLE: begin
					idx_q <= 6'h0;
					cnt_q <= '0;
					if (start) begin
						sp_run_q <= wsp;
						st_q     <= auto_page_erase_q ? FPPS_ERASE : FPPS_WRITE;
					end
				end
				FPPS_ERASE: begin
					st_q <= FPPS_WRITE;
				end
				FPPS_WRITE: begin
					idx_q <= idx_q + 6'h1;
					if (idx_q == LAST_IDX) begin
						st_q <= FPPS_SETTLE;
					end
				end
				FPPS_SETTLE: begin
					cnt_q <= cnt_q + 1'b1;
					if (cnt_q == CNT_W'(PROG_CYCLES - 1)) begin
						st_q <= FPPS_DONE;
					end
				end
				FPPS_DONE: begin
					st_q <= FPPS_IDLE;
				end
				default: begin
					st_q <= FPPS_IDLE;
				end
			endcase
		end
	end

	always_ff @(posedge clock) begin
		if (srst) begin
			busy_q  <= 1'b0;
			stall_q <= 1'b0;
		end else if (abort || st_q == FPPS_DONE) begin
			busy_q  <= 1'b0;
			stall_q <= 1'b0;
		end else if (start) begin
			busy_q  <= 1'b1;
			stall_q <= exec_internal;
		end
	end

	// skipped locations keep old cells, or stay FFh after erase
	always_ff @(posedge clock) begin
		if (srst) begin
			flash_q <= '0;
		end else begin
			flash_q.erase <= st_q == FPPS_ERASE && !abort;
			flash_q.wr    <= st_q == FPPS_WRITE && !abort && loaded_q[idx_q];
			flash_q.space <= sp_run_q;
			flash_q.addr  <= st_q == FPPS_ERASE ? {page_q, PAGE_BASE}
				: {page_q, half_q, idx_q};
			flash_q.data  <= buf_q[idx_q];
		end
	end

	assign avs_waitrequest = wait_q;
	assign avs_readdata    = rdata_q;
	assign ram_wr_valid    = ram_v_q;
	assign ram_wr          = ram_q;
	assign code_space      = space_q;
	assign cpu_stall       = stall_q;
	assign flash           = flash_q;

	// settle cycles of the current run; a counter, as 40 repeats would be unrolled
	logic [CNT_W-1:0] settle_run_q;

	always_ff @(posedge clock) begin
		if (srst) begin
			settle_run_q <= '0;
		end else if (st_q == FPPS_SETTLE) begin
			settle_run_q <= settle_run_q + 1'b1;
		end else begin
			settle_run_q <= '0;
		end
	end

	sequence arm_s;
		fc_wr && key == KEY_ARM && st_q == FPPS_IDLE;
	endsequence
	sequence go_s;
		fc_wr && key == KEY_GO && wsp != SP_RSVD;
	endsequence
	sequence gap_s;
		(!instr_step && !fc_wr) [*2];
	endsequence

	key_launch_a: assert property (@(posedge clock) disable iff (srst)
		arm_s ##1 gap_s ##1 go_s |=> busy_q && st_q != FPPS_IDLE)
		else $error("key sequence did not launch");
	lone_key_a: assert property (@(posedge clock) disable iff (srst)
		$rose(busy_q) |-> $past(armed_q) && $past(fc_wr))
		else $error("busy rose without armed key");
	step_abort_a: assert property (@(posedge clock) disable iff (srst)
		instr_step && !fc_wr |=> !armed_q)
		else $error("instruction did not disarm key");
	busy_run_a: assert property (@(posedge clock) disable iff (srst || bo_s_q)
		start |=> busy_q throughout (st_q != FPPS_IDLE) [*8])
		else $error("busy dropped while running");
	err_set_a: assert property (@(posedge clock) disable iff (srst)
		abort |=> err_q && !busy_q && st_q == FPPS_IDLE)
		else $error("brown-out abort not flagged");
	reload_ign_a: assert property (@(posedge clock) disable iff (srst)
		ld && loaded_q[ld_idx] |=> buf_q[$past(ld_idx)] == $past(buf_q[ld_idx]))
		else $error("loaded location overwritten");
	buf_clear_a: assert property (@(posedge clock) disable iff (srst)
		st_q == FPPS_DONE |=> loaded_q == 64'h0 && !busy_q)
		else $error("buffer not emptied after operation");
	erase_first_a: assert property (@(posedge clock) disable iff (srst)
		start && auto_page_erase_q |=> ##1 flash_q.erase && flash_q.addr[A_PG_LO-1:0] == PAGE_BASE)
		else $error("auto-erase pulse missing");
	no_erase_a: assert property (@(posedge clock) disable iff (srst)
		start && !auto_page_erase_q |=> !flash_q.erase [*8])
		else $error("erase without auto-erase");
	settle_len_a: assert property (@(posedge clock) disable iff (srst)
		st_q == FPPS_DONE |-> settle_run_q == CNT_W'(PROG_CYCLES))
		else $error("programming time wrong");
	code_map_a: assert property (@(posedge clock) disable iff (srst)
		fc_wr |=> code_space == $past(wsp))
		else $error("code-read mapping not taken");
	ram_redirect_a: assert property (@(posedge clock) disable iff (srst)
		xwr_valid |=> ram_wr_valid == !$past(map_q))
		else $error("data write not redirected");
	stall_follow_a: assert property (@(posedge clock) disable iff (srst)
		start |=> cpu_stall == $past(exec_internal))
		else $error("stall does not follow code origin");
	wr_loaded_a: assert property (@(posedge clock) disable iff (srst)
		st_q == FPPS_WRITE && !loaded_q[idx_q] |=> !flash_q.wr)
		else $error("unloaded location programmed");
	page_pick_a: assert property (@(posedge clock) disable iff (srst)
		flash_q.wr |-> flash_q.addr[A_PG_HI:A_PG_LO] == page_q)
		else $error("wrong target page");
	rsvd_noop_a: assert property (@(posedge clock) disable iff (srst)
		fc_wr && wsp == SP_RSVD && !busy_q |=> !busy_q && st_q == FPPS_IDLE)
		else $error("reserved space launched");
	err_keep_a: assert property (@(posedge clock) disable iff (srst)
		err_q && !nvm_wr |=> err_q)
		else $error("error flag lost");
endmodule : fpps_top

// File: tb/fpps_flash_model.sv
// Purpose: flash array model on the sequencer's program port
// Assumes: one page image indexed by the low seven address bits
// Notes:   cells only lose ones unless erased, so stale data shows up
`timescale 1ns/1ps
module fpps_flash_model
	import fpps_pkg::*;
(
	input wire logic        clock,
	input wire fpps_flash_s flash
);
	logic [7:0]  mem [128];
	logic [15:0] last_addr;
	logic [1:0]  last_sp;
	initial last_sp = 2'b11;
	always @(posedge clock) begin
		if (flash.erase) begin
			foreach (mem[i]) mem[i] <= 8'hff;
		end
		if (flash.wr) begin
			mem[flash.addr[6:0]] <= mem[flash.addr[6:0]] & flash.data;
			last_addr <= flash.addr;
			last_sp <= flash.space;
		end
	end
endmodule : fpps_flash_model

// File: tb/fpps_tb_top.sv
// Purpose: self-checking bench for the flash page program sequencer
// Assumes: registered slave, master waits on waitrequest only
// Notes:   array contents judged through the flash model
`timescale 1ns/1ps
module fpps_tb_top
	import fpps_pkg::*;
;
	logic        clock = 1'b0;
	logic        srst = 1'b1;
	logic [3:0]  avs_address = 4'h0;
	logic        avs_read = 1'b0;
	logic        avs_write = 1'b0;
	logic [31:0] avs_writedata = 32'h0;
	logic [31:0] avs_readdata;
	logic        avs_waitrequest;
	logic        xwr_valid = 1'b0;
	fpps_xwr_s   xwr = '0;
	logic        instr_step = 1'b0;
	logic        exec_internal = 1'b1;
	logic        brownout = 1'b0;
	logic        ram_wr_valid;
	fpps_xwr_s   ram_wr;
	logic [1:0]  code_space;
	logic        cpu_stall;
	fpps_flash_s flash;
	int          bad_count = 0;
	int          total_checks = 0;
	int          cycles = 0;
	logic [31:0] rd;
	always #25 clock = ~clock;
	fpps_top dut (
		.clock(clock),
		.srst(srst),
		.avs_address(avs_address),
		.avs_read(avs_read),
		.avs_write(avs_write),
		.avs_writedata(avs_writedata),
		.avs_readdata(avs_readdata),
		.avs_waitrequest(avs_waitrequest),
		.xwr_valid(xwr_valid),
		.xwr(xwr),
		.instr_step(instr_step),
		.exec_internal(exec_internal),
		.brownout(brownout),
		.ram_wr_valid(ram_wr_valid),
		.ram_wr(ram_wr),
		.code_space(code_space),
		.cpu_stall(cpu_stall),
		.flash(flash)
	);
	fpps_flash_model fm (
		.clock(clock),
		.flash(flash)
	);
	task automatic chk(input logic [31:0] s, input logic [31:0] e);
		total_checks++;
		if (s !== e) begin
			bad_count++;
			$display("ERROR %0t: got %h expected %h", $time, s, e);
		end
	endtask : chk
	task automatic bw(input logic [3:0] a, input logic [7:0] d);
		@(posedge clock);
		avs_address <= a;
		avs_writedata <= {24'h0, d};
		avs_write <= 1'b1;
		@(posedge clock);
		while (avs_waitrequest !== 1'b0) @(posedge clock);
		avs_write <= 1'b0;
	endtask : bw
	task automatic br(input logic [3:0] a);
		@(posedge clock);
		avs_address <= a;
		avs_read <= 1'b1;
		@(posedge clock);
		while (avs_waitrequest !== 1'b0) @(posedge clock);
		rd = avs_readdata;
		avs_read <= 1'b0;
	endtask : br
	task automatic ld(input logic [15:0] a, input logic [7:0] d);
		@(posedge clock);
		xwr_valid <= 1'b1;
		xwr <= '{a, d};
		@(posedge clock);
		xwr_valid <= 1'b0;
	endtask : ld
	// keys written back to back, no instruction step between them
	task automatic go(input logic [1:0] s);
		bw(OFS_FCTL, {KEY_ARM, 1'b0, s, 1'b0});
		bw(OFS_FCTL, {KEY_GO, 1'b0, s, 1'b0});
	endtask : go
	task automatic idle_wait;
		rd = 32'h1;
		// polling only: no interrupt work while programming runs
		while (rd[0] !== 1'b0) br(OFS_STAT);
	endtask : idle_wait
	task automatic t_reset;
		br(OFS_FCTL);
		chk(rd, 32'h0);
		br(OFS_NVM);
		chk(rd, 32'h0);
		chk(code_space, SP_CODE);
		$display("done reset");
	endtask : t_reset
	task automatic t_map;
		logic [7:0] m [3] = '{8'h02, 8'h04, 8'h00};
		foreach (m[i]) begin
			bw(OFS_FCTL, m[i]);
			@(negedge clock);
			chk(code_space, m[i][2:1]);
		end
		$display("done map");
	endtask : t_map
	task automatic t_ram;
		ld(16'h0010, 8'h77);
		@(negedge clock);
		chk({ram_wr_valid, ram_wr}, {1'b1, 16'h0010, 8'h77});
		$display("done ram");
	endtask : t_ram
	// first load names another page, so only the last load may pick it
	task automatic t_erase;
		bw(OFS_NVM, 8'h40);
		bw(OFS_FCTL, 8'h08);
		br(OFS_FCTL);
		chk(rd, 32'h08);
		ld(16'h0a41, 8'h11);
		ld(16'h1240, 8'h5a);
		ld(16'h1240, 8'h00);
		ld(16'h127f, 8'h3c);
		@(negedge clock);
		chk(ram_wr_valid, 1'b0);
		bw(OFS_FCTL, 8'h00);
		go(SP_CODE);
		repeat (3) @(negedge clock);
		chk(cpu_stall, 1'b1);
		br(OFS_FCTL);
		chk(rd[0], 1'b1);
		idle_wait;
		chk(cpu_stall, 1'b0);
		chk({fm.mem[0], fm.mem[7'h40], fm.mem[7'h41], fm.mem[7'h7f]}, 32'hff5a113c);
		chk({fm.last_sp, fm.last_addr[15:7]}, {SP_CODE, 9'h024});
		$display("done erase");
	endtask : t_erase
	// same index reloaded each pass: stale buffer would keep old data
	task automatic t_space;
		logic [7:0] d [3] = '{8'h00, 8'h0f, 8'h33};
		logic [7:0] e [3] = '{8'h00, 8'h0f, 8'h03};
		bw(OFS_NVM, 8'h00);
		for (int s = 1; s < 3; s++) begin
			bw(OFS_FCTL, 8'h08);
			ld(16'h0005, d[s]);
			bw(OFS_FCTL, 8'h00);
			go(2'(s));
			idle_wait;
			chk({fm.last_sp, fm.mem[5], fm.mem[7'h40]}, {2'(s), e[s], 8'h5a});
		end
		$display("done space");
	endtask : t_space
	task automatic t_abort;
		bw(OFS_FCTL, 8'h08);
		ld(16'h0007, 8'h00);
		bw(OFS_FCTL, 8'h50);
		@(posedge clock);
		instr_step <= 1'b1;
		@(posedge clock);
		instr_step <= 1'b0;
		bw(OFS_FCTL, 8'ha0);
		br(OFS_STAT);
		chk(rd[0], 1'b0);
		bw(OFS_FCTL, 8'h50);
		bw(OFS_FCTL, 8'h00);
		bw(OFS_FCTL, 8'ha0);
		br(OFS_STAT);
		chk(rd[0], 1'b0);
		go(SP_RSVD);
		br(OFS_STAT);
		chk(rd[0], 1'b0);
		$display("done abort");
	endtask : t_abort
	task automatic t_ext;
		exec_internal <= 1'b0;
		go(SP_CODE);
		br(OFS_STAT);
		chk({rd[2], rd[0]}, 2'b01);
		idle_wait;
		chk(fm.mem[7], 8'h00);
		exec_internal <= 1'b1;
		$display("done external");
	endtask : t_ext
	task automatic t_brown;
		bw(OFS_FCTL, 8'h08);
		ld(16'h0009, 8'h00);
		bw(OFS_FCTL, 8'h00);
		go(SP_CODE);
		repeat (5) @(posedge clock);
		brownout <= 1'b1;
		repeat (3) @(posedge clock);
		brownout <= 1'b0;
		repeat (2) @(negedge clock);
		chk(cpu_stall, 1'b0);
		br(OFS_NVM);
		chk(rd[NVM_ERR], 1'b1);
		bw(OFS_NVM, 8'h00);
		br(OFS_NVM);
		chk(rd[NVM_ERR], 1'b0);
		$display("done brownout");
	endtask : t_brown
	task automatic end_of_test;
		$display("checks %0d mismatches %0d", total_checks, bad_count);
		if (bad_count == 0 && total_checks > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask : end_of_test
	// whole run needs about six hundred cycles
	always @(posedge clock) begin
		cycles <= cycles + 1;
		if (cycles == 5000) begin
			bad_count++;
			end_of_test;
		end
	end
	initial begin
		repeat (4) @(posedge clock);
		srst <= 1'b0;
		t_reset;
		t_map;
		t_ram;
		t_erase;
		t_space;
		t_abort;
		t_ext;
		t_brown;
		end_of_test;
	end
endmodule : fpps_tb_top
